// >>> rtl/exc_vector_pkg.sv
package exc_vector_pkg;

  // status word and opcode word field positions
  localparam int SW_T1_BIT = 15;
  localparam int SW_T0_BIT = 14;
  localparam int SW_S_BIT = 13;
  localparam int OPCLASS_HI = 15;
  localparam int OPCLASS_LO = 12;

  // opcode line classes in bits [15:12]
  localparam logic [3:0] OP_A_LINE = 4'hA;
  localparam logic [3:0] OP_F_LINE = 4'hF;

  // vector numbers
  localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_DIV_ZERO = 8'h05;
  localparam logic [7:0] VEC_BOUNDS = 8'h06;
  localparam logic [7:0] VEC_COND_TRAP = 8'h07;
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_A_LINE = 8'h0A;
  localparam logic [7:0] VEC_F_LINE = 8'h0B;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;

  // reset values
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] SW_RST = 16'h0000;

  // decoder's verdict on the instruction word
  typedef enum logic [3:0] {
    k_normal, k_illegal, k_ctrl_move, k_trap_n, k_div, k_bounds, k_range,
    k_cond_trap, k_fcond_trap, k_ovf_trap, k_fp_legal, k_fp_unimpl
  } insn_kind_type;

  typedef enum logic [1:0] {
    fmt_short, fmt_trap_ptr, fmt_addr_err, fmt_fp_ea
  } frame_fmt_type;

  typedef struct packed {
    insn_kind_type kind;
    logic [15:0] op_word;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic [3:0] trap_num;
    logic priv;
    logic ctrl_reg_bad;
    logic divisor_zero;
    logic cond_true;
    logic ea_needed;
    logic [31:0] ea;
  } insn_info_type;

  typedef struct packed {
    frame_fmt_type fmt;
    logic [7:0] vector;
    logic [11:0] vec_offset;
    logic [15:0] saved_sw;
    logic [31:0] pc;
    logic [31:0] insn_addr;
    logic [31:0] fault_addr;
  } frame_type;

  typedef struct packed {
    logic take;
    logic fetch;
    logic [7:0] vector;
    frame_fmt_type fmt;
  } decision_type;

endpackage : exc_vector_pkg

// >>> rtl/exc_vector_unit.sv
`timescale 1ns/10ps

module exc_vector_unit (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // decoded instruction
  input wire logic insn_valid_i,
  input wire exc_vector_pkg::insn_info_type insn_i,
  output logic insn_take_o,
  output logic insn_exec_o,
  input wire logic pipe_busy_i,
  // prefetch and branch
  input wire logic pf_req_i,
  input wire logic [31:0] pf_addr_i,
  input wire logic [31:0] pf_insn_addr_i,
  output logic pf_go_o,
  input wire logic br_not_taken_i,
  input wire logic [31:0] br_target_i,
  // breakpoint acknowledge cycle
  input wire logic bkpt_cycle_i,
  input wire logic [31:0] bkpt_pc_i,
  input wire logic transfer_ack_i,
  input wire logic transfer_error_ack_i,
  // processor state
  input wire logic [15:0] status_word_i,
  input wire logic [31:0] vbr_i,
  input wire logic reset_exc_i,
  output logic [15:0] status_word_o,
  output logic status_load_o,
  // float operand fetch
  output logic op_req_o,
  output logic [31:0] op_addr_o,
  input wire logic op_done_i,
  // stacking
  output logic frame_valid_o,
  output exc_vector_pkg::frame_type frame_o,
  input wire logic frame_done_i,
  // vector fetch and resume
  output logic vec_req_o,
  output logic [31:0] vec_addr_o,
  input wire logic vec_done_i,
  input wire logic [31:0] handler_i,
  output logic pc_load_o,
  output logic [31:0] new_pc_o,
  // status
  output logic busy_o,
  output logic halted_o
);
  import exc_vector_pkg::*;

  typedef enum logic [2:0] {st_idle, st_opfetch, st_stack, st_vecfetch, st_halt} state_type;

  state_type state_ff;
  frame_type frame_ff;
  decision_type dec;
  logic ae_pend_ff, ae_active_ff, bkpt_pend_ff;
  logic [31:0] ae_addr_ff, ae_insn_ff, vec_addr_ff, new_pc_ff;
  logic [15:0] sw_new_ff;
  logic sw_load_ff, pc_load_ff;
  logic [1:0] ack_meta_ff, ack_sync_ff, ack_prev_ff;
  logic pf_odd, br_odd, ae_odd, idle, bkpt_end, start_bkpt, start_insn, start_ae;
  logic [15:0] sw_entry;

  // decode priority: opcode validity, then privilege, then traps
  function automatic decision_type classify(insn_info_type i, logic user);
    decision_type d;
    d = '{take: 1'b1, fetch: 1'b0, vector: VEC_ILLEGAL, fmt: fmt_short};
    if (i.op_word[OPCLASS_HI:OPCLASS_LO] == OP_A_LINE) begin
      d.vector = VEC_A_LINE;
    end else if (i.op_word[OPCLASS_HI:OPCLASS_LO] == OP_F_LINE &&
                 i.kind != k_fp_legal && i.kind != k_fp_unimpl) begin
      d.vector = VEC_F_LINE;
    end else if (i.kind == k_illegal) begin
      d.vector = VEC_ILLEGAL;
    end else if (i.priv && user) begin
      d.vector = VEC_PRIV;
    end else if (i.kind == k_ctrl_move && i.ctrl_reg_bad) begin
      d.vector = VEC_ILLEGAL;
    end else if (i.kind == k_fp_unimpl) begin
      d.vector = VEC_F_LINE;
      d.fetch = i.ea_needed;
      d.fmt = fmt_fp_ea;
    end else if (i.kind == k_trap_n) begin
      // software trap stacks no instruction pointer
      d.vector = VEC_TRAP_BASE + {4'h0, i.trap_num};
      d.fmt = fmt_short;
    end else if (i.kind == k_div && i.divisor_zero) begin
      d.vector = VEC_DIV_ZERO;
      d.fmt = fmt_trap_ptr;
    end else if ((i.kind == k_bounds || i.kind == k_range) && i.cond_true) begin
      d.vector = VEC_BOUNDS;
      d.fmt = fmt_trap_ptr;
    end else if ((i.kind == k_cond_trap || i.kind == k_fcond_trap ||
                  i.kind == k_ovf_trap) && i.cond_true) begin
      d.vector = VEC_COND_TRAP;
      d.fmt = fmt_trap_ptr;
    end else begin
      d.take = 1'b0;
    end
    return d;
  endfunction : classify

  // event detection and start arbitration
  assign idle = (state_ff == st_idle);
  assign pf_odd = pf_req_i && pf_addr_i[0];
  assign br_odd = br_not_taken_i && br_target_i[0];
  assign ae_odd = pf_odd || br_odd;
  // first edge of either acknowledge only, so one cycle enters once
  assign bkpt_end = bkpt_cycle_i && (ack_sync_ff != 2'b00) && (ack_prev_ff == 2'b00);
  assign dec = classify(insn_i, !status_word_i[SW_S_BIT]);
  assign start_bkpt = idle && bkpt_pend_ff;
  assign start_insn = idle && !bkpt_pend_ff && insn_valid_i && dec.take;
  // an exception from the running instructions always beats the pending address error
  assign start_ae = idle && ae_pend_ff && !pipe_busy_i && !bkpt_pend_ff &&
                    !(insn_valid_i && dec.take);

  // status copy with supervisor set and tracing off
  always_comb begin
    sw_entry = status_word_i;
    sw_entry[SW_S_BIT] = 1'b1;
    sw_entry[SW_T1_BIT] = 1'b0;
    sw_entry[SW_T0_BIT] = 1'b0;
  end

  // handshake outputs
  assign pf_go_o = pf_req_i && !pf_addr_i[0] && (state_ff != st_halt);
  assign insn_take_o = idle && !bkpt_pend_ff && insn_valid_i;
  assign insn_exec_o = insn_take_o && !dec.take;
  assign frame_valid_o = (state_ff == st_stack);
  assign vec_req_o = (state_ff == st_vecfetch);
  assign op_req_o = (state_ff == st_opfetch);
  assign op_addr_o = frame_ff.fault_addr;
  assign frame_o = frame_ff;
  assign vec_addr_o = vec_addr_ff;
  assign new_pc_o = new_pc_ff;
  assign pc_load_o = pc_load_ff;
  assign status_word_o = sw_new_ff;
  assign status_load_o = sw_load_ff;
  assign busy_o = !idle;
  assign halted_o = (state_ff == st_halt);

  // acknowledge pins come from the bus, so two stages first
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ack_meta_ff <= 2'b00;
      ack_sync_ff <= 2'b00;
      ack_prev_ff <= 2'b00;
    end else begin
      ack_meta_ff <= {transfer_error_ack_i, transfer_ack_i};
      ack_sync_ff <= ack_meta_ff;
      ack_prev_ff <= ack_sync_ff;
    end
  end

  // pending address error; a new odd fetch is ignored while one is already pending
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ae_pend_ff <= 1'b0;
      ae_addr_ff <= ADDR_RST;
      ae_insn_ff <= ADDR_RST;
    end else if (idle && ae_odd && !ae_pend_ff) begin
      ae_pend_ff <= 1'b1;
      ae_addr_ff <= pf_odd ? pf_addr_i : br_target_i;
      ae_insn_ff <= pf_insn_addr_i;
    end else if (start_ae) begin
      ae_pend_ff <= 1'b0;
    end
  end

  // double fault window lasts until the handler's first good prefetch
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ae_active_ff <= 1'b0;
    end else if (start_ae) begin
      ae_active_ff <= 1'b1;
    end else if (idle && pf_go_o) begin
      ae_active_ff <= 1'b0;
    end
  end

  // breakpoint acknowledge end, served as illegal instruction
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bkpt_pend_ff <= 1'b0;
    end else if (bkpt_end) begin
      bkpt_pend_ff <= 1'b1;
    end else if (start_bkpt) begin
      bkpt_pend_ff <= 1'b0;
    end
  end

  // sequencer and frame capture
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_ff <= st_idle;
      frame_ff <= '0;
      vec_addr_ff <= ADDR_RST;
      new_pc_ff <= ADDR_RST;
      sw_new_ff <= SW_RST;
      sw_load_ff <= 1'b0;
      pc_load_ff <= 1'b0;
    end else begin
      sw_load_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      if ((ae_active_ff || reset_exc_i) && ae_odd && state_ff != st_halt) begin
        state_ff <= st_halt;
      end else begin
        case (state_ff)
          st_idle: begin
            if (start_bkpt || start_insn || start_ae) begin
              sw_new_ff <= sw_entry;
              sw_load_ff <= 1'b1;
              frame_ff.saved_sw <= status_word_i;
              state_ff <= st_stack;
            end
            if (start_bkpt) begin
              frame_ff.fmt <= fmt_short;
              frame_ff.vector <= VEC_ILLEGAL;
              frame_ff.vec_offset <= {2'b00, VEC_ILLEGAL, 2'b00};
              frame_ff.pc <= bkpt_pc_i;
              frame_ff.insn_addr <= bkpt_pc_i;
              frame_ff.fault_addr <= ADDR_RST;
            end else if (start_insn) begin
              frame_ff.fmt <= dec.fmt;
              frame_ff.vector <= dec.vector;
              frame_ff.vec_offset <= {2'b00, dec.vector, 2'b00};
              // traps and float ops resume after; faults restart at their own word
              frame_ff.pc <= (dec.fmt == fmt_short && dec.vector < VEC_TRAP_BASE) ?
                             insn_i.pc : insn_i.next_pc;
              frame_ff.insn_addr <= insn_i.pc;
              frame_ff.fault_addr <= insn_i.ea;
              if (dec.fetch) begin
                state_ff <= st_opfetch;
              end
            end else if (start_ae) begin
              frame_ff.fmt <= fmt_addr_err;
              frame_ff.vector <= VEC_ADDR_ERR;
              frame_ff.vec_offset <= {2'b00, VEC_ADDR_ERR, 2'b00};
              frame_ff.pc <= ae_insn_ff;
              frame_ff.insn_addr <= ae_insn_ff;
              frame_ff.fault_addr <= {ae_addr_ff[31:1], 1'b0};
            end
          end
          st_opfetch: begin
            if (op_done_i) begin
              state_ff <= st_stack;
            end
          end
          st_stack: begin
            if (frame_done_i) begin
              vec_addr_ff <= vbr_i + {22'h00_0000, frame_ff.vector, 2'b00};
              state_ff <= st_vecfetch;
            end
          end
          st_vecfetch: begin
            if (vec_done_i) begin
              new_pc_ff <= handler_i;
              pc_load_ff <= 1'b1;
              state_ff <= st_idle;
            end
          end
          default: begin
            state_ff <= st_halt;
          end
        endcase
      end
    end
  end

  // checks
  sequence s_entry(logic [7:0] v);
    (state_ff == st_stack || state_ff == st_opfetch) && frame_ff.vector == v;
  endsequence

  sequence s_clean_sw;
    status_load_o && status_word_o[SW_S_BIT] && !status_word_o[SW_T1_BIT] &&
      !status_word_o[SW_T0_BIT];
  endsequence

  a_odd_no_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    pf_odd |-> !pf_go_o) else $error("odd prefetch ran a bus cycle");
  a_branch_odd_pend: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    idle && br_odd && !ae_pend_ff && !(ae_active_ff || reset_exc_i)
      |=> ae_pend_ff) else $error("odd not-taken branch missed");
  a_ae_waits_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    idle && ae_pend_ff && pipe_busy_i && !insn_valid_i && !bkpt_pend_ff && !ae_odd
      |=> idle) else $error("address error started while busy");
  a_ae_frame_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    start_ae && !ae_odd |=> s_entry(VEC_ADDR_ERR) ##0 frame_ff.fault_addr[0] == 1'b0
      ##0 frame_ff.vec_offset == 12'h00C) else $error("address error frame wrong");
  a_double_fault_halt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ae_active_ff && ae_odd |=> halted_o [*3]) else $error("no double fault halt");
  a_trap_n_vector: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    start_insn && dec.vector >= VEC_TRAP_BASE && insn_i.kind == k_trap_n && !ae_odd
      |=> s_entry(8'h20 + {4'h0, $past(insn_i.trap_num)})) else $error("trap vector wrong");
  a_div_nonzero_runs: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    insn_take_o && insn_i.kind == k_div && !insn_i.divisor_zero && !insn_i.priv &&
      insn_i.op_word[15:13] != 3'b111 && insn_i.op_word[15:12] != 4'hA |-> insn_exec_o)
    else $error("divide trapped without zero divisor");
  a_entry_status: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (start_insn || start_ae || start_bkpt) && !ae_odd |=> s_clean_sw)
    else $error("entry status word wrong");
  a_priv_violation: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    start_insn && dec.vector == VEC_PRIV && !ae_odd |-> !insn_exec_o
      ##1 (s_entry(VEC_PRIV) ##0 frame_ff.pc == $past(insn_i.pc)))
    else $error("privilege violation frame wrong");
  a_fp_fetch_first: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    start_insn && dec.fetch && !ae_odd |=> op_req_o && !frame_valid_o)
    else $error("float operand not fetched first");
  a_vector_address: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_ff == st_stack && frame_done_i && !ae_odd |=> vec_req_o &&
      vec_addr_o == $past(vbr_i) + {22'h00_0000, frame_ff.vector, 2'b00})
    else $error("vector address wrong");

endmodule : exc_vector_unit

// >>> sim/tb.sv
`timescale 1ns/10ps
module tb;
  import exc_vector_pkg::*;
  // one table row: instruction stimulus beside the exception it should raise
  typedef struct packed {
    insn_kind_type kind; logic [15:0] op; logic [3:0] n;
    logic priv, sup, bad, dz, ct, exc; logic [7:0] vec; frame_fmt_type fmt; logic nxt;
  } row_type;
  logic clk_sys_i, rst_n_i, insn_valid_i, pipe_busy_i, pf_req_i, br_not_taken_i;
  logic bkpt_cycle_i, transfer_ack_i, transfer_error_ack_i, reset_exc_i;
  logic op_done_i, frame_done_i, vec_done_i;
  logic [31:0] pf_addr_i, pf_insn_addr_i, br_target_i, bkpt_pc_i, vbr_i, handler_i;
  logic [15:0] status_word_i;
  insn_info_type insn_i;
  logic insn_take_o, insn_exec_o, pf_go_o, status_load_o, op_req_o, frame_valid_o;
  logic vec_req_o, pc_load_o, busy_o, halted_o;
  logic [15:0] status_word_o;
  logic [31:0] op_addr_o, vec_addr_o, new_pc_o;
  frame_type frame_o;
  int fail_count;
  int n_checks;
  row_type rows [21];

  exc_vector_unit u_exc_vector_unit (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
    .insn_take_o(insn_take_o), .insn_exec_o(insn_exec_o), .pipe_busy_i(pipe_busy_i),
    .pf_req_i(pf_req_i), .pf_addr_i(pf_addr_i), .pf_insn_addr_i(pf_insn_addr_i),
    .pf_go_o(pf_go_o), .br_not_taken_i(br_not_taken_i), .br_target_i(br_target_i),
    .bkpt_cycle_i(bkpt_cycle_i), .bkpt_pc_i(bkpt_pc_i), .transfer_ack_i(transfer_ack_i),
    .transfer_error_ack_i(transfer_error_ack_i), .status_word_i(status_word_i),
    .vbr_i(vbr_i), .reset_exc_i(reset_exc_i), .status_word_o(status_word_o),
    .status_load_o(status_load_o), .op_req_o(op_req_o), .op_addr_o(op_addr_o),
    .op_done_i(op_done_i), .frame_valid_o(frame_valid_o), .frame_o(frame_o),
    .frame_done_i(frame_done_i), .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o),
    .vec_done_i(vec_done_i), .handler_i(handler_i), .pc_load_o(pc_load_o),
    .new_pc_o(new_pc_o), .busy_o(busy_o), .halted_o(halted_o)
  );

  // free-running 100 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // a hang counts as a mismatch and ends the run
  task automatic to(input string nm);
    fail_count++;
    $display("Error %s expected handshake seen timeout", nm);
    tally_and_finish();
  endtask : to

  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    chk("halted_rst", halted_o, 1'b0);
    chk("busy_rst", busy_o, 1'b0);
    chk("pulses_rst", {status_load_o, pc_load_o, frame_o === '0}, 3'h1);
  endtask : do_reset

  // present insn_i for one accepted cycle; entered and left 1 ns after an edge
  task automatic issue(input logic exc);
    insn_valid_i = 1'b1;
    #1 chk("take", insn_take_o, 1'b1);
    chk("exec", insn_exec_o, !exc);
    @(posedge clk_sys_i);
    #1 insn_valid_i = 1'b0;
  endtask : issue

  // whole exception entry: status load, optional operand fetch, frame, vector, resume
  task automatic exc_seq(input logic [7:0] v, input frame_fmt_type f, input logic [31:0] pc,
                         input logic [31:0] ia, input logic [31:0] fa, input logic aux,
                         input logic opx);
    int k;
    int ops;
    logic got;
    logic [15:0] sw;
    got = 1'b0;
    ops = 0;
    sw = 16'h0000;
    // the operand fetch is stalled for two cycles before it completes
    for (k = 0; k < 60; k++) begin
      if (status_load_o === 1'b1) begin
        got = 1'b1;
        sw = status_word_o;
      end
      if (frame_valid_o === 1'b1) break;
      op_done_i = (op_req_o === 1'b1 && ops == 2);
      if (op_req_o === 1'b1) begin
        ops++;
        chk("op_addr", op_addr_o, fa);
      end
      @(posedge clk_sys_i);
      #1 op_done_i = 1'b0;
    end
    if (frame_valid_o !== 1'b1) to("frame_valid");
    chk("sw_load", got, 1'b1);
    chk("sw_new", sw, (status_word_i | 16'h2000) & 16'h3FFF);
    chk("op_fetch", ops > 0, opx);
    chk("vector", frame_o.vector, v);
    chk("fmt", frame_o.fmt, f);
    chk("offset", frame_o.vec_offset, {2'b00, v, 2'b00});
    chk("pc", frame_o.pc, pc);
    chk("saved_sw", frame_o.saved_sw, status_word_i);
    if (aux) begin
      chk("insn_addr", frame_o.insn_addr, ia);
      chk("fault_addr", frame_o.fault_addr, fa);
    end
    chk("refuse", {busy_o, insn_take_o}, 2'h2);
    frame_done_i = 1'b1;
    @(posedge clk_sys_i);
    #1 frame_done_i = 1'b0;
    for (k = 0; k < 20 && vec_req_o !== 1'b1; k++) @(posedge clk_sys_i) #1;
    if (vec_req_o !== 1'b1) to("vec_req");
    chk("vec_addr", vec_addr_o, vbr_i + {22'h00_0000, v, 2'b00});
    vec_done_i = 1'b1;
    handler_i = 32'h0002_0040;
    @(posedge clk_sys_i);
    #1 vec_done_i = 1'b0;
    for (k = 0; k < 20 && pc_load_o !== 1'b1; k++) @(posedge clk_sys_i) #1;
    if (pc_load_o !== 1'b1) to("pc_load");
    chk("new_pc", new_pc_o, 32'h0002_0040);
    chk("busy_end", busy_o, 1'b0);
  endtask : exc_seq

  initial begin
    int i;
    row_type r;
    {insn_valid_i, pipe_busy_i, pf_req_i, br_not_taken_i, bkpt_cycle_i} = 5'h00;
    {transfer_ack_i, transfer_error_ack_i, reset_exc_i, op_done_i} = 4'h0;
    {frame_done_i, vec_done_i} = 2'b00;
    {pf_addr_i, pf_insn_addr_i, br_target_i, bkpt_pc_i, handler_i} = '0;
    insn_i = '0;
    status_word_i = 16'hC700;
    vbr_i = 32'h0001_0000;
    fail_count = 0;
    n_checks = 0;
    rows = '{
      '{k_normal, 16'h4E71, 4'h0, 0, 1, 0, 0, 0, 0, 8'h00, fmt_short, 0},
      '{k_illegal, 16'h4AFC, 4'h0, 0, 1, 0, 0, 0, 1, 8'h04, fmt_short, 0},
      '{k_ctrl_move, 16'h4E7B, 4'h0, 1, 1, 1, 0, 0, 1, 8'h04, fmt_short, 0},
      '{k_ctrl_move, 16'h4E7B, 4'h0, 1, 1, 0, 0, 0, 0, 8'h00, fmt_short, 0},
      '{k_normal, 16'hA000, 4'h0, 0, 1, 0, 0, 0, 1, 8'h0A, fmt_short, 0},
      '{k_normal, 16'hF000, 4'h0, 0, 1, 0, 0, 0, 1, 8'h0B, fmt_short, 0},
      '{k_fp_legal, 16'hF200, 4'h0, 0, 1, 0, 0, 0, 0, 8'h00, fmt_short, 0},
      '{k_normal, 16'h46C0, 4'h0, 1, 0, 0, 0, 0, 1, 8'h08, fmt_short, 0},
      '{k_normal, 16'h46C0, 4'h0, 1, 1, 0, 0, 0, 0, 8'h00, fmt_short, 0},
      '{k_trap_n, 16'h4E45, 4'h5, 0, 0, 0, 0, 0, 1, 8'h25, fmt_short, 1},
      '{k_trap_n, 16'h4E4F, 4'hF, 0, 1, 0, 0, 0, 1, 8'h2F, fmt_short, 1},
      '{k_div, 16'h81C0, 4'h0, 0, 0, 0, 1, 0, 1, 8'h05, fmt_trap_ptr, 1},
      '{k_div, 16'h81C0, 4'h0, 0, 0, 0, 0, 0, 0, 8'h00, fmt_short, 0},
      '{k_bounds, 16'h4180, 4'h0, 0, 0, 0, 0, 1, 1, 8'h06, fmt_trap_ptr, 1},
      '{k_range, 16'h00C0, 4'h0, 0, 0, 0, 0, 1, 1, 8'h06, fmt_trap_ptr, 1},
      '{k_bounds, 16'h4180, 4'h0, 0, 0, 0, 0, 0, 0, 8'h00, fmt_short, 0},
      '{k_cond_trap, 16'h50FC, 4'h0, 0, 0, 0, 0, 1, 1, 8'h07, fmt_trap_ptr, 1},
      '{k_fcond_trap, 16'h5000, 4'h0, 0, 0, 0, 0, 1, 1, 8'h07, fmt_trap_ptr, 1},
      '{k_ovf_trap, 16'h4E76, 4'h0, 0, 0, 0, 0, 1, 1, 8'h07, fmt_trap_ptr, 1},
      '{k_cond_trap, 16'h50FC, 4'h0, 0, 0, 0, 0, 0, 0, 8'h00, fmt_short, 0},
      '{k_fp_unimpl, 16'hF200, 4'h0, 0, 0, 0, 0, 0, 1, 8'h0B, fmt_fp_ea, 1}
    };
    do_reset();
    // table of decode cases, each excepting one run to the end of its exception entry
    for (i = 0; i < 21; i++) begin
      r = rows[i];
      insn_i = '0;
      insn_i.kind = r.kind;
      insn_i.op_word = r.op;
      insn_i.pc = 32'h0000_1000 + 32'(i * 16);
      insn_i.next_pc = insn_i.pc + 32'h0000_0004;
      {insn_i.trap_num, insn_i.priv, insn_i.ctrl_reg_bad} = {r.n, r.priv, r.bad};
      {insn_i.divisor_zero, insn_i.cond_true} = {r.dz, r.ct};
      insn_i.ea = 32'h0000_5554;
      status_word_i = r.sup ? 16'hE700 : 16'hC700;
      issue(r.exc);
      if (r.exc) begin
        exc_seq(r.vec, r.fmt, r.nxt ? insn_i.next_pc : insn_i.pc, insn_i.pc, insn_i.ea, 1, 0);
      end else begin
        chk("no_exc", {status_load_o, frame_valid_o, op_req_o}, 3'h0);
      end
    end
    // float operand fetched before the frame, stalled by the memory side
    insn_i.ea_needed = 1'b1;
    insn_i.ea = 32'h0000_6000;
    issue(1'b1);
    exc_seq(8'h0B, fmt_fp_ea, insn_i.next_pc, insn_i.pc, 32'h0000_6000, 1, 1);
    // even prefetch runs, odd one is suppressed and waits for the pipe
    status_word_i = 16'hC700;
    {pf_req_i, pf_addr_i, pf_insn_addr_i} = {1'b1, 32'h0000_3000, 32'h0000_2FFE};
    #1 chk("pf_even", pf_go_o, 1'b1);
    @(posedge clk_sys_i);
    #1 {pipe_busy_i, pf_addr_i} = {1'b1, 32'h0000_3001};
    #1 chk("pf_odd", pf_go_o, 1'b0);
    @(posedge clk_sys_i);
    #1 pf_req_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 chk("ae_wait", {status_load_o, frame_valid_o}, 2'h0);
    pipe_busy_i = 1'b0;
    exc_seq(8'h03, fmt_addr_err, 32'h0000_2FFE, 32'h0000_2FFE, 32'h0000_3000, 1, 0);
    // a good prefetch closes the window, then an odd not-taken branch
    {pf_req_i, pf_addr_i} = {1'b1, 32'h0000_3004};
    @(posedge clk_sys_i);
    #1 {pf_req_i, br_not_taken_i, br_target_i} = {1'b0, 1'b1, 32'h0000_4003};
    pf_insn_addr_i = 32'h0000_3FFC;
    @(posedge clk_sys_i);
    #1 br_not_taken_i = 1'b0;
    exc_seq(8'h03, fmt_addr_err, 32'h0000_3FFC, 32'h0000_3FFC, 32'h0000_4002, 1, 0);
    // odd prefetch inside the address error window halts for good
    {pf_req_i, pf_addr_i} = {1'b1, 32'h0000_5001};
    @(posedge clk_sys_i);
    #1 pf_req_i = 1'b0;
    chk("dbl_fault_ae", {halted_o, pf_go_o}, 2'h2);
    repeat (4) @(posedge clk_sys_i);
    #1 chk("stay_halted", halted_o, 1'b1);
    do_reset();
    // odd prefetch during reset processing halts as well
    {reset_exc_i, pf_req_i} = 2'h3;
    @(posedge clk_sys_i);
    #1 {reset_exc_i, pf_req_i} = 2'h0;
    chk("dbl_fault_rst", halted_o, 1'b1);
    do_reset();
    // breakpoint cycle ended by either acknowledge
    for (i = 0; i < 2; i++) begin
      {bkpt_cycle_i, transfer_ack_i, transfer_error_ack_i} = {1'b1, i == 0, i == 1};
      bkpt_pc_i = 32'h0000_7000 + 32'(i * 16);
      repeat (4) @(posedge clk_sys_i);
      #1 {bkpt_cycle_i, transfer_ack_i, transfer_error_ack_i} = 3'h0;
      exc_seq(8'h04, fmt_short, bkpt_pc_i, 32'h0, 32'h0, 0, 0);
    end
    tally_and_finish();
  end
endmodule : tb
